// >>> hw/twowire_pkg.sv
// Constants, field positions and state type shared by the two-wire block
package twowire_pkg;
   // Special-function register addresses
   localparam logic [7:0] CTRL_ADDR = 8'he8;
   localparam logic [7:0] SEC_ADDR_ADDR = 8'hf2;
   localparam logic [7:0] DATA_ADDR = 8'h9a;
   localparam logic [7:0] PRI_ADDR_ADDR = 8'h9b;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] SEC_ADDR_RST = 8'h7f;
   localparam logic [7:0] PRI_ADDR_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   // Control register field positions
   localparam int MDO_POS = 7;
   localparam int MDE_POS = 6;
   localparam int MCO_POS = 5;
   localparam int MDI_POS = 4;
   localparam int ROLE_POS = 3;
   localparam int IRS_POS = 2;
   localparam int DIR_POS = 1;
   localparam int DONE_POS = 0;
   // Shared service vector with the synchronous serial port
   localparam logic [7:0] IRQ_VECTOR = 8'h3b;
   // Bits per byte on the wire
   localparam logic [3:0] BYTE_BITS = 4'h8;
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_RX, S_TX, S_TACK} slv_state_t;
endpackage

// >>> hw/twowire_link_if.sv
// Signals between the register/pin front end and the slave engine
`timescale 1ns/1ps
interface twowire_link_if;
   logic scl_rise;
   logic scl_fall;
   logic sda_lvl;
   logic start_p;
   logic stop_p;
   logic eng_rst;
   logic [6:0] own_addr;
   logic [6:0] alt_addr;
   logic [7:0] tx_byte;
   logic [7:0] rx_byte;
   logic byte_done_p;
   logic tx_dir;
   logic pull_sda;
   modport front (output scl_rise, scl_fall, sda_lvl, start_p, stop_p, eng_rst, own_addr,
      alt_addr, tx_byte, input rx_byte, byte_done_p, tx_dir, pull_sda);
   modport eng (input scl_rise, scl_fall, sda_lvl, start_p, stop_p, eng_rst, own_addr,
      alt_addr, tx_byte, output rx_byte, byte_done_p, tx_dir, pull_sda);
endinterface

// >>> hw/twowire_slave_engine.sv
// Hardware slave byte engine: address match, receive, transmit, acknowledge
`timescale 1ns/1ps
module twowire_slave_engine
   import twowire_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Link to front end
   twowire_link_if.eng lk
);
   slv_state_t state_ff, nxt_state;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [7:0] sh_ff, nxt_sh;
   logic [7:0] rx_ff, nxt_rx;
   logic pull_ff, nxt_pull;
   logic dir_ff, nxt_dir;
   logic done_ff, nxt_done;
   logic addr_hit;

   assign addr_hit = (sh_ff[7:1] == lk.own_addr) || (sh_ff[7:1] == lk.alt_addr);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_sh = sh_ff;
      nxt_rx = rx_ff;
      nxt_pull = pull_ff;
      nxt_dir = dir_ff;
      nxt_done = 1'b0;
      if (lk.eng_rst || lk.stop_p) begin
         nxt_state = S_IDLE;
         nxt_cnt = 4'h0;
         nxt_pull = 1'b0;
      end else if (lk.start_p) begin
         nxt_state = S_ADDR;
         nxt_cnt = 4'h0;
         nxt_pull = 1'b0;
      end else begin
         unique case (state_ff)
            S_IDLE: begin
            end
            S_ADDR, S_RX: begin
               if (lk.scl_rise && cnt_ff < BYTE_BITS) begin
                  nxt_sh = {sh_ff[6:0], lk.sda_lvl};
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (lk.scl_fall && cnt_ff == BYTE_BITS) begin
                  if (state_ff == S_ADDR) begin
                     // Foreign addresses leave the bus untouched
                     nxt_state = addr_hit ? S_AACK : S_IDLE;
                     nxt_pull = addr_hit;
                     nxt_dir = addr_hit ? sh_ff[0] : dir_ff;
                  end else begin
                     nxt_rx = sh_ff;
                     nxt_done = 1'b1;
                     nxt_state = S_AACK;
                     nxt_pull = 1'b1;
                  end
               end
            end
            S_AACK: begin
               if (lk.scl_fall) begin
                  nxt_cnt = 4'h0;
                  if (dir_ff) begin
                     nxt_state = S_TX;
                     nxt_sh = lk.tx_byte;
                     nxt_pull = ~lk.tx_byte[7];
                  end else begin
                     nxt_state = S_RX;
                     nxt_pull = 1'b0;
                  end
               end
            end
            S_TX: begin
               if (lk.scl_rise) begin
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (lk.scl_fall) begin
                  if (cnt_ff == BYTE_BITS) begin
                     nxt_pull = 1'b0;
                     nxt_state = S_TACK;
                     nxt_done = 1'b1;
                  end else begin
                     nxt_sh = {sh_ff[6:0], 1'b0};
                     nxt_pull = ~sh_ff[6];
                  end
               end
            end
            S_TACK: begin
               // No acknowledge from the master ends the read
               if (lk.scl_rise && lk.sda_lvl) begin
                  nxt_state = S_IDLE;
               end else if (lk.scl_fall) begin
                  nxt_state = S_TX;
                  nxt_cnt = 4'h0;
                  nxt_sh = lk.tx_byte;
                  nxt_pull = ~lk.tx_byte[7];
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_ff <= S_IDLE;
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         rx_ff <= 8'h00;
         pull_ff <= 1'b0;
         dir_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         sh_ff <= nxt_sh;
         rx_ff <= nxt_rx;
         pull_ff <= nxt_pull;
         dir_ff <= nxt_dir;
         done_ff <= nxt_done;
      end
   end

   assign lk.rx_byte = rx_ff;
   assign lk.pull_sda = pull_ff;
   assign lk.tx_dir = dir_ff;
   assign lk.byte_done_p = done_ff;

   property p_addr_ack;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_ff == S_ADDR && lk.scl_fall && cnt_ff == BYTE_BITS && addr_hit && !lk.eng_rst
         && !lk.stop_p && !lk.start_p) |=> (pull_ff && state_ff == S_AACK);
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("matching address not acked");

   property p_addr_ignore;
      @(posedge ref_clk) disable iff (sys_rst)
      (state_ff == S_ADDR && lk.scl_fall && cnt_ff == BYTE_BITS && !addr_hit && !lk.eng_rst
         && !lk.stop_p && !lk.start_p) |=> (!pull_ff && state_ff == S_IDLE);
   endproperty
   a_addr_ignore: assert property (p_addr_ignore) else $error("foreign address acked");

   property p_dir_latch;
      @(posedge ref_clk) disable iff (sys_rst)
      ($past(state_ff) == S_ADDR && state_ff == S_AACK) |-> dir_ff == $past(sh_ff[0]);
   endproperty
   a_dir_latch: assert property (p_dir_latch) else $error("direction not taken");
endmodule // twowire_slave_engine

// >>> hw/twowire_port.sv
// Two-wire port: control registers, pin synchronisers, software master, slave hookup
`timescale 1ns/1ps
module twowire_port
   import twowire_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Special-function register access
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Dedicated serial clock pin
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   // Dedicated serial data pin
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe,
   // Service request toward the shared vector
   output logic twowire_irq
);
   twowire_link_if lk ();

   logic [2:0] scl_sync_ff, nxt_scl_sync;
   logic [2:0] sda_sync_ff, nxt_sda_sync;
   logic scl_lvl_ff, nxt_scl_lvl;
   logic sda_lvl_ff, nxt_sda_lvl;
   logic scl_prev_ff, nxt_scl_prev;
   logic sda_prev_ff, nxt_sda_prev;

   logic master_data_out_bit, nxt_mdo;
   logic master_data_drive_enable, nxt_mde;
   logic master_clock_out_bit, nxt_mco;
   logic master_data_in_bit, nxt_mdi;
   logic role_select, nxt_role;
   logic interface_reset_bit, nxt_irs;
   logic byte_done_flag, nxt_done;
   logic [7:0] sec_addr_ff, nxt_sec_addr;
   logic [7:0] pri_addr_ff, nxt_pri_addr;
   logic [7:0] tx_data_ff, nxt_tx_data;
   logic [7:0] rdata_ff, nxt_rdata;
   logic ctrl_wr, data_rd, scl_edge;
   logic [7:0] ctrl_view;

   assign ctrl_wr = sfr_wr && sfr_addr == CTRL_ADDR;
   assign data_rd = sfr_rd && sfr_addr == DATA_ADDR;
   assign scl_edge = scl_lvl_ff ^ scl_prev_ff;

   // Pin synchronisers; a level counts once stages two and three agree
   always_comb begin
      nxt_scl_sync = {scl_sync_ff[1:0], scl_in};
      nxt_sda_sync = {sda_sync_ff[1:0], serial_data_pin_in};
      nxt_scl_lvl = (scl_sync_ff[1] == scl_sync_ff[2]) ? scl_sync_ff[2] : scl_lvl_ff;
      nxt_sda_lvl = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_lvl_ff;
      nxt_scl_prev = scl_lvl_ff;
      nxt_sda_prev = sda_lvl_ff;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         scl_sync_ff <= 3'h7;
         sda_sync_ff <= 3'h7;
         scl_lvl_ff <= 1'b1;
         sda_lvl_ff <= 1'b1;
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
      end else begin
         scl_sync_ff <= nxt_scl_sync;
         sda_sync_ff <= nxt_sda_sync;
         scl_lvl_ff <= nxt_scl_lvl;
         sda_lvl_ff <= nxt_sda_lvl;
         scl_prev_ff <= nxt_scl_prev;
         sda_prev_ff <= nxt_sda_prev;
      end
   end

   // Register file
   always_comb begin
      nxt_mdo = master_data_out_bit;
      nxt_mde = master_data_drive_enable;
      nxt_mco = master_clock_out_bit;
      nxt_role = role_select;
      nxt_irs = interface_reset_bit;
      nxt_sec_addr = sec_addr_ff;
      nxt_pri_addr = pri_addr_ff;
      nxt_tx_data = tx_data_ff;
      nxt_mdi = master_data_in_bit;
      nxt_done = byte_done_flag;
      if (ctrl_wr) begin
         nxt_mdo = sfr_wdata[MDO_POS];
         nxt_mde = sfr_wdata[MDE_POS];
         nxt_mco = sfr_wdata[MCO_POS];
         nxt_role = sfr_wdata[ROLE_POS];
         nxt_irs = sfr_wdata[IRS_POS];
      end
      if (sfr_wr && sfr_addr == SEC_ADDR_ADDR) begin
         nxt_sec_addr = sfr_wdata;
      end
      if (sfr_wr && sfr_addr == PRI_ADDR_ADDR) begin
         nxt_pri_addr = sfr_wdata;
      end
      if (sfr_wr && sfr_addr == DATA_ADDR) begin
         nxt_tx_data = sfr_wdata;
      end
      // Input sampling only while the pin is released by the master
      if (role_select && !master_data_drive_enable && scl_edge) begin
         nxt_mdi = sda_lvl_ff;
      end
      // Flag is hardware owned; a byte arriving with the read still sets it
      if (data_rd) begin
         nxt_done = 1'b0;
      end
      if (lk.byte_done_p && !role_select) begin
         nxt_done = 1'b1;
      end
   end

   assign ctrl_view = {master_data_out_bit, master_data_drive_enable, master_clock_out_bit,
      master_data_in_bit, role_select, interface_reset_bit, lk.tx_dir, byte_done_flag};

   always_comb begin
      unique case (sfr_addr)
         CTRL_ADDR: nxt_rdata = ctrl_view;
         SEC_ADDR_ADDR: nxt_rdata = sec_addr_ff;
         PRI_ADDR_ADDR: nxt_rdata = pri_addr_ff;
         DATA_ADDR: nxt_rdata = lk.rx_byte;
         default: nxt_rdata = 8'h00;
      endcase
      if (!sfr_rd) begin
         nxt_rdata = rdata_ff;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         master_data_out_bit <= CTRL_RST[MDO_POS];
         master_data_drive_enable <= CTRL_RST[MDE_POS];
         master_clock_out_bit <= CTRL_RST[MCO_POS];
         master_data_in_bit <= CTRL_RST[MDI_POS];
         role_select <= CTRL_RST[ROLE_POS];
         interface_reset_bit <= CTRL_RST[IRS_POS];
         byte_done_flag <= CTRL_RST[DONE_POS];
         sec_addr_ff <= SEC_ADDR_RST;
         pri_addr_ff <= PRI_ADDR_RST;
         tx_data_ff <= DATA_RST;
         rdata_ff <= 8'h00;
      end else begin
         master_data_out_bit <= nxt_mdo;
         master_data_drive_enable <= nxt_mde;
         master_clock_out_bit <= nxt_mco;
         master_data_in_bit <= nxt_mdi;
         role_select <= nxt_role;
         interface_reset_bit <= nxt_irs;
         byte_done_flag <= nxt_done;
         sec_addr_ff <= nxt_sec_addr;
         pri_addr_ff <= nxt_pri_addr;
         tx_data_ff <= nxt_tx_data;
         rdata_ff <= nxt_rdata;
      end
   end

   assign sfr_rdata = rdata_ff;
   // Level request; the handler must also poll the synchronous port
   assign twowire_irq = byte_done_flag;

   // Slave engine hookup; master role also parks the engine
   assign lk.scl_rise = scl_lvl_ff && !scl_prev_ff;
   assign lk.scl_fall = !scl_lvl_ff && scl_prev_ff;
   assign lk.sda_lvl = sda_lvl_ff;
   assign lk.start_p = scl_lvl_ff && scl_prev_ff && sda_prev_ff && !sda_lvl_ff;
   assign lk.stop_p = scl_lvl_ff && scl_prev_ff && !sda_prev_ff && sda_lvl_ff;
   assign lk.eng_rst = interface_reset_bit || role_select;
   assign lk.own_addr = pri_addr_ff[6:0];
   assign lk.alt_addr = sec_addr_ff[6:0];
   assign lk.tx_byte = tx_data_ff;

   twowire_slave_engine u_engine (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .lk(lk)
   );

   // Pin drivers: software master owns both lines, slave only pulls data low
   always_comb begin
      if (role_select) begin
         scl_out = master_clock_out_bit;
         scl_oe = 1'b1;
         serial_data_pin_out = master_data_out_bit;
         serial_data_pin_oe = master_data_drive_enable;
      end else begin
         scl_out = 1'b0;
         scl_oe = 1'b0;
         serial_data_pin_out = 1'b0;
         serial_data_pin_oe = lk.pull_sda && !interface_reset_bit;
      end
   end

   property p_sec_reset;
      @(posedge ref_clk) sys_rst |=> sec_addr_ff == SEC_ADDR_RST;
   endproperty
   a_sec_reset: assert property (p_sec_reset) else $error("secondary address reset wrong");

   property p_sda_drive;
      @(posedge ref_clk) disable iff (sys_rst)
      (role_select && master_data_drive_enable) |-> serial_data_pin_oe
         && serial_data_pin_out == master_data_out_bit;
   endproperty
   a_sda_drive: assert property (p_sda_drive) else $error("master data not driven");

   property p_sda_input;
      @(posedge ref_clk) disable iff (sys_rst)
      (role_select && !master_data_drive_enable) |-> !serial_data_pin_oe;
   endproperty
   a_sda_input: assert property (p_sda_input) else $error("data pin not released");

   property p_scl_drive;
      @(posedge ref_clk) disable iff (sys_rst)
      role_select |-> scl_oe && scl_out == master_clock_out_bit;
   endproperty
   a_scl_drive: assert property (p_scl_drive) else $error("master clock not driven");

   property p_mdi_capture;
      @(posedge ref_clk) disable iff (sys_rst)
      (role_select && !master_data_drive_enable && scl_edge) |=>
         master_data_in_bit == $past(sda_lvl_ff);
   endproperty
   a_mdi_capture: assert property (p_mdi_capture) else $error("data in not captured");

   property p_role_write;
      @(posedge ref_clk) disable iff (sys_rst)
      ctrl_wr |=> role_select == $past(sfr_wdata[ROLE_POS])
         && scl_oe == $past(sfr_wdata[ROLE_POS]);
   endproperty
   a_role_write: assert property (p_role_write) else $error("role select not taken");

   property p_slave_reset;
      @(posedge ref_clk) disable iff (sys_rst)
      (!role_select && interface_reset_bit) |-> !serial_data_pin_oe ##1 !lk.byte_done_p;
   endproperty
   a_slave_reset: assert property (p_slave_reset) else $error("slave active in reset");

   property p_done_set;
      @(posedge ref_clk) disable iff (sys_rst)
      (lk.byte_done_p && !role_select) |=> byte_done_flag && twowire_irq;
   endproperty
   a_done_set: assert property (p_done_set) else $error("byte done flag not set");

   property p_done_clear;
      @(posedge ref_clk) disable iff (sys_rst)
      (data_rd && !lk.byte_done_p) |=> !byte_done_flag;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("data read kept flag");
endmodule // twowire_port

// >>> tb/bus_master_model.sv
// Behavioural far-side bus master: open-drain drive of both lines
`timescale 1ns/1ps
module bus_master_model (
   // Open-drain pulls, high while holding the line low
   output logic scl_low,
   output logic sda_low,
   // Resolved data line
   input wire logic sda
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // Offset keeps line changes away from the sampling clock edge
   task automatic start();
      #3 sda_low = 1'b1;
      #32 scl_low = 1'b1;
   endtask
   // Long low phase: the slave answers about five port clocks after a fall
   task automatic bit_io(input logic b, output logic r);
      #16 sda_low = !b;
      #28 scl_low = 1'b0;
      #16 r = sda;
      #4 scl_low = 1'b1;
   endtask
   // Data level held by the bench while the port owns the clock
   task automatic hold_data(input logic low);
      #3 sda_low = low;
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], ack);
      end
      bit_io(1'b1, ack);
   endtask
   task automatic rd_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(nack, r);
   endtask
   task automatic stop();
      #16 sda_low = 1'b1;
      #16 scl_low = 1'b0;
      #32 sda_low = 1'b0;
      #32;
   endtask
endmodule // bus_master_model

// >>> tb/tb_top.sv
// Self-checking bench for the two-wire port
`timescale 1ns/1ps
module tb_top
   import twowire_pkg::*;
;
   logic ref_clk, sys_rst, sfr_wr, sfr_rd;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic scl_out, scl_oe, sda_out, sda_oe, twowire_irq, scl_low, sda_low;
   wire logic scl_pin, sda_pin;
   int failures, compares;
   // Pull-ups on both lines; released lines read high
   assign scl_pin = scl_oe ? scl_out : !scl_low;
   assign sda_pin = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);

   twowire_port twowire_port_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .scl_in(scl_pin), .scl_out(scl_out), .scl_oe(scl_oe), .serial_data_pin_in(sda_pin),
      .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe), .twowire_irq(twowire_irq));
   bus_master_model bus_master_model_i (.scl_low(scl_low), .sda_low(sda_low), .sda(sda_pin));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge ref_clk);
      sfr_rd <= 1'b0;
      @(negedge ref_clk);
      d = sfr_rdata;
   endtask
   // Let the pin synchronisers settle before looking at captured levels
   task automatic settle();
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic t_regs();
      logic [7:0] d;
      rd(CTRL_ADDR, d); check(d, CTRL_RST, "control reset");
      rd(SEC_ADDR_ADDR, d); check(d, SEC_ADDR_RST, "alt address reset");
      wr(SEC_ADDR_ADDR, 8'h5a);
      rd(SEC_ADDR_ADDR, d); check(d, 8'h5a, "alt address readback");
      wr(8'h55, 8'hff);
      rd(8'h55, d); check(d, 8'h00, "unmapped read");
      wr(CTRL_ADDR, 8'h13);
      rd(CTRL_ADDR, d); check(d, 8'h00, "hardware bits not writable");
      $display("test regs finished");
   endtask

   task automatic t_master_pins();
      for (int i = 0; i < 4; i++) begin
         wr(CTRL_ADDR, {i[1], 1'b1, i[0], 5'h08});
         settle();
         check({7'h0, scl_oe}, 8'h01, "clock driven");
         check({7'h0, scl_out}, {7'h0, i[0]}, "clock level");
         check({7'h0, sda_oe}, 8'h01, "data driven");
         check({7'h0, sda_out}, {7'h0, i[1]}, "data level");
      end
      wr(CTRL_ADDR, 8'h08);
      settle();
      check({7'h0, sda_oe}, 8'h00, "data input");
      wr(CTRL_ADDR, 8'h00);
      settle();
      check({7'h0, scl_oe}, 8'h00, "slave leaves clock");
      $display("test master pins finished");
   endtask

   task automatic t_master_capture();
      logic [7:0] d;
      wr(CTRL_ADDR, 8'h08);
      bus_master_model_i.hold_data(1'b1);
      wr(CTRL_ADDR, 8'h28);
      settle();
      rd(CTRL_ADDR, d); check(d & 8'h10, 8'h00, "low captured");
      bus_master_model_i.hold_data(1'b0);
      wr(CTRL_ADDR, 8'h08);
      settle();
      rd(CTRL_ADDR, d); check(d & 8'h10, 8'h10, "high captured on fall");
      // Port drives the pin low, so a wrong capture would clear the bit
      wr(CTRL_ADDR, 8'h48);
      wr(CTRL_ADDR, 8'h68);
      settle();
      rd(CTRL_ADDR, d); check(d & 8'h10, 8'h10, "no capture while driving");
      wr(CTRL_ADDR, 8'h00);
      $display("test master capture finished");
   endtask

   task automatic t_slave_write();
      logic a;
      logic [7:0] d;
      wr(SEC_ADDR_ADDR, 8'h50);
      bus_master_model_i.start();
      bus_master_model_i.wr_byte({7'h50, 1'b0}, a);
      check({7'h0, a}, 8'h00, "alt address acked");
      bus_master_model_i.wr_byte(8'ha5, a);
      check({7'h0, a}, 8'h00, "data acked");
      @(negedge ref_clk);
      check({7'h0, twowire_irq}, 8'h01, "request raised");
      wr(CTRL_ADDR, 8'h00);
      rd(CTRL_ADDR, d); check(d & 8'h03, 8'h01, "receive dir, flag kept");
      rd(DATA_ADDR, d); check(d, 8'ha5, "received byte");
      check({7'h0, twowire_irq}, 8'h00, "read clears flag");
      bus_master_model_i.stop();
      $display("test slave write finished");
   endtask

   task automatic t_slave_read();
      logic a;
      logic [7:0] d;
      wr(PRI_ADDR_ADDR, 8'h21);
      wr(DATA_ADDR, 8'h3c);
      bus_master_model_i.start();
      bus_master_model_i.wr_byte({7'h21, 1'b1}, a);
      check({7'h0, a}, 8'h00, "primary acked");
      bus_master_model_i.rd_byte(1'b1, d);
      check(d, 8'h3c, "sent byte");
      bus_master_model_i.stop();
      rd(CTRL_ADDR, d); check(d & 8'h03, 8'h03, "transmit dir, flag set");
      rd(DATA_ADDR, d);
      rd(CTRL_ADDR, d); check(d & 8'h01, 8'h00, "flag cleared");
      $display("test slave read finished");
   endtask

   task automatic t_refuse();
      logic a;
      bus_master_model_i.start();
      bus_master_model_i.wr_byte({7'h33, 1'b0}, a);
      check({7'h0, a}, 8'h01, "foreign address ignored");
      bus_master_model_i.stop();
      wr(CTRL_ADDR, 8'h04);
      bus_master_model_i.start();
      bus_master_model_i.wr_byte({7'h21, 1'b0}, a);
      check({7'h0, a}, 8'h01, "held in reset");
      bus_master_model_i.wr_byte(8'h5a, a);
      check({7'h0, a}, 8'h01, "data ignored in reset");
      bus_master_model_i.stop();
      check({7'h0, twowire_irq}, 8'h00, "no request");
      wr(CTRL_ADDR, 8'h00);
      bus_master_model_i.start();
      bus_master_model_i.wr_byte({7'h21, 1'b0}, a);
      check({7'h0, a}, 8'h00, "resumes after clear");
      bus_master_model_i.stop();
      $display("test refuse finished");
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Whole run needs well under 30 us
   initial begin
      #200000;
      failures++;
      conclude();
   end

   initial begin
      failures = 0;
      compares = 0;
      sys_rst = 1'b1;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_master_pins();
      t_master_capture();
      t_slave_write();
      t_slave_read();
      t_refuse();
      conclude();
   end
endmodule // tb_top
